// [core/scic_pkg.sv]
/*
 * Constants for the card interrupt identification, enable and selection block.
 * Assumes an 8051-style special-function-register bus with 8-bit addresses.
 */
package scic_pkg;
   // shared special-function addresses
   localparam logic [7:0] SEL_ADDR = 8'hab;
   localparam logic [7:0] IRQ_ADDR = 8'hae;
   // identification and enable bit positions
   localparam int unsigned TXBUF_BIT = 7;
   localparam int unsigned RSVD_BIT = 6;
   localparam int unsigned CURR_BIT = 5;
   localparam int unsigned VOLT_BIT = 4;
   localparam int unsigned WAIT_BIT = 3;
   localparam int unsigned TXD_BIT = 2;
   localparam int unsigned RXD_BIT = 1;
   localparam int unsigned PAR_BIT = 0;
   localparam logic [7:0] IRQ_MASK = 8'hbf;
   localparam logic [7:0] IRQ_RESET = 8'h00;
   // selection register fields
   localparam int unsigned RETRY_BIT = 4;
   localparam int unsigned DIV_LSB = 2;
   localparam int unsigned ROUTE_BIT = 1;
   localparam int unsigned BANK_BIT = 0;
   localparam logic [7:0] SEL_MASK = 8'h1f;
   localparam logic [7:0] SEL_RESET = 8'h08;
   // retries before a parity error is reported
   localparam logic [2:0] RETRY_CLR = 3'h5;
   localparam logic [2:0] RETRY_SET = 3'h4;
endpackage

// [core/scic_irq_select.sv]
/*
 * Card interface interrupt identification, interrupt enable and selection.
 * Holds the read-to-clear flag register, its enable register, the selection
 * register with retry count, alternate clock prescaler and bank select.
 * Assumes all inputs except reset_n are synchronous to sys_clk and event inputs are
 * one-cycle pulses from the card UART, buffer and wait timer logic.
 */
// Functional notes
// R1: transmit buffer copy into shift register sets flag bit 7.
// R2: reading the identification register clears all its flags; no write path.
// R3: card current leaving its range sets flag bit 5.
// R4: card voltage leaving the selected range sets flag bit 4.
// R5: wait timer timeout sets flag bit 3.
// R6: character transmission done sets flag bit 2.
// R7: character reception done sets flag bit 1.
// R8: parity error sets bit 0 together with transmit or receive flag.
// R9: each flag has an enable bit at the same position; set enables.
// R10: enable register is read-write at AEh while bank select is 1.
// R11: retry select bit 4 clear gives five repetitions, set gives four.
// R12: prescaler bits 3-2 divide by 1, 2, 4, 8; reset code 10.
// R13: route bit 1 drives prescaled clock to pin, else ordinary port function.
// R14: bank select bit 0 chooses which register set the shared addresses hit.
// R15: software writes zero to reserved bit 6 and ignores its value.
// R16: defined identification and enable bits are zero after reset.
// R17: identification register is read-only at AEh while bank select is 0.
// R18: one interrupt request while any flag and its enable are both set.
// R19: an event in the cycle of a clearing read keeps its flag set.
`timescale 1ns/10ps
module scic_irq_select (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   output logic sfr_rdata_valid,
   input wire logic tx_buf_load,
   input wire logic card_current_over,
   input wire logic card_voltage_ok,
   input wire logic wait_timeout,
   input wire logic tx_char_done,
   input wire logic rx_char_done,
   input wire logic parity_error,
   input wire logic port_func_out,
   output logic card_irq,
   output logic [2:0] retry_limit,
   output logic register_bank_select,
   output logic alt_clock_route,
   output logic alt_clk_pin_out
);

   // reset release synchroniser
   logic rst_meta_q;
   logic rst_n_q;

   // register state
   logic [7:0] flag_q;
   logic [7:0] flag_d;
   logic [7:0] en_q;
   logic [7:0] en_d;
   logic [7:0] sel_q;
   logic [7:0] sel_d;
   logic curr_over_q;
   logic volt_ok_q;
   logic [2:0] div_cnt_q;
   logic [2:0] div_cnt_d;
   logic alt_tgl_q;
   logic alt_tgl_d;
   logic [7:0] rdata_q;
   logic rvalid_q;
   logic irq_q;
   logic [2:0] retry_q;
   logic bank_q;
   logic route_q;
   logic pin_q;

   // address decode
   wire bank = sel_q[scic_pkg::BANK_BIT];
   wire hit_irq = sfr_addr == scic_pkg::IRQ_ADDR;
   wire hit_sel = sfr_addr == scic_pkg::SEL_ADDR;
   wire id_rd = sfr_rd && hit_irq && !bank; // [R17] [R14]
   wire en_wr = sfr_wr && hit_irq && bank; // [R10] [R14]
   wire sel_wr = sfr_wr && hit_sel;
   wire any_rd = sfr_rd && (hit_irq || hit_sel);

   // event detection; level inputs are edge-detected so a held fault
   // does not keep re-arming the flag after a clearing read
   wire curr_rise = card_current_over && !curr_over_q;
   wire volt_fall = !card_voltage_ok && volt_ok_q;
   wire char_done = tx_char_done || rx_char_done;
   wire [7:0] evt;
   assign evt[scic_pkg::TXBUF_BIT] = tx_buf_load; // [R1]
   assign evt[scic_pkg::RSVD_BIT] = 1'b0; // [R15]
   assign evt[scic_pkg::CURR_BIT] = curr_rise; // [R3]
   assign evt[scic_pkg::VOLT_BIT] = volt_fall; // [R4]
   assign evt[scic_pkg::WAIT_BIT] = wait_timeout; // [R5]
   assign evt[scic_pkg::TXD_BIT] = tx_char_done; // [R6]
   assign evt[scic_pkg::RXD_BIT] = rx_char_done; // [R7]
   assign evt[scic_pkg::PAR_BIT] = parity_error && char_done; // [R8]

   // register next values; the flags have no write path at all
   assign en_d = en_wr ? (sfr_wdata & scic_pkg::IRQ_MASK) : en_q; // [R9] [R10]
   assign sel_d = sel_wr ? (sfr_wdata & scic_pkg::SEL_MASK) : sel_q;

   // read mux; reserved bits read as zero
   wire [7:0] rd_mux = hit_sel ? sel_q : (bank ? en_q : flag_q);

   // selection fields
   wire [1:0] div_code = sel_q[scic_pkg::DIV_LSB +: 2];
   wire route = sel_q[scic_pkg::ROUTE_BIT];
   wire [2:0] div_last = 3'((4'h1 << div_code) - 4'h1); // [R12]
   wire div_wrap = div_cnt_q == div_last;
   assign div_cnt_d = (!route || div_wrap) ? 3'h0 : div_cnt_q + 3'h1;
   assign alt_tgl_d = route ? (alt_tgl_q ^ div_wrap) : 1'b0;
   wire pin_d = route ? alt_tgl_d : port_func_out; // [R13]
   wire [2:0] retry_d = sel_q[scic_pkg::RETRY_BIT] ? scic_pkg::RETRY_SET
                                                   : scic_pkg::RETRY_CLR; // [R11]
   wire pend = |(flag_q & en_q); // [R18]

   // per-bit flag update: set wins over the clearing read
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_flag
         assign flag_d[gi] = scic_pkg::IRQ_MASK[gi] &&
                             (evt[gi] || (flag_q[gi] && !id_rd)); // [R2] [R19]
      end
   endgenerate

   // reset release through two stages
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // identification, enable and selection registers
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         flag_q <= scic_pkg::IRQ_RESET; // [R16]
         en_q <= scic_pkg::IRQ_RESET; // [R16]
         sel_q <= scic_pkg::SEL_RESET; // [R12]
         curr_over_q <= 1'b0;
         volt_ok_q <= 1'b0;
      end else if (clk_en) begin
         flag_q <= flag_d;
         en_q <= en_d;
         sel_q <= sel_d;
         curr_over_q <= card_current_over;
         volt_ok_q <= card_voltage_ok;
      end
   end

   // alternate clock prescaler; held low while not routed
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         div_cnt_q <= 3'h0;
         alt_tgl_q <= 1'b0;
      end else if (clk_en) begin
         div_cnt_q <= div_cnt_d;
         alt_tgl_q <= alt_tgl_d;
      end
   end

   // read data and registered outputs
   always_ff @(posedge sys_clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
         irq_q <= 1'b0;
         retry_q <= scic_pkg::RETRY_CLR;
         bank_q <= 1'b0;
         route_q <= 1'b0;
         pin_q <= 1'b0;
      end else if (clk_en) begin
         rdata_q <= any_rd ? rd_mux : rdata_q;
         rvalid_q <= any_rd;
         irq_q <= pend; // [R18] [R9]
         retry_q <= retry_d; // [R11]
         bank_q <= bank; // [R14]
         route_q <= route;
         pin_q <= pin_d; // [R13]
      end
   end

   assign sfr_rdata = rdata_q;
   assign sfr_rdata_valid = rvalid_q;
   assign card_irq = irq_q;
   assign retry_limit = retry_q;
   assign register_bank_select = bank_q;
   assign alt_clock_route = route_q;
   assign alt_clk_pin_out = pin_q;

   // checks on the flag, enable and selection behaviour
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n_q);

   txbuf_flag_set_a: // [R1]
      assert property (clk_en && tx_buf_load |=> flag_q[scic_pkg::TXBUF_BIT])
      else $error("transmit buffer flag not set");

   read_clears_a: // [R2]
      assert property (clk_en && id_rd && evt == 8'h00 |=> flag_q == 8'h00)
      else $error("identification read did not clear flags");

   current_flag_set_a: // [R3]
      assert property (clk_en && card_current_over && !curr_over_q
                       |=> flag_q[scic_pkg::CURR_BIT])
      else $error("current error flag not set");

   voltage_flag_set_a: // [R4]
      assert property (clk_en && volt_ok_q && !card_voltage_ok
                       |=> flag_q[scic_pkg::VOLT_BIT])
      else $error("voltage error flag not set");

   wait_flag_set_a: // [R5]
      assert property (clk_en && wait_timeout |=> flag_q[scic_pkg::WAIT_BIT])
      else $error("wait timeout flag not set");

   tx_flag_set_a: // [R6]
      assert property (clk_en && tx_char_done |=> flag_q[scic_pkg::TXD_BIT])
      else $error("transmit flag not set");

   rx_flag_set_a: // [R7]
      assert property (clk_en && rx_char_done |=> flag_q[scic_pkg::RXD_BIT])
      else $error("receive flag not set");

   parity_with_char_a: // [R8]
      assert property ($rose(flag_q[scic_pkg::PAR_BIT])
                       |-> flag_q[scic_pkg::TXD_BIT] || flag_q[scic_pkg::RXD_BIT])
      else $error("parity flag set without character flag");

   irq_follows_a: // [R18]
      assert property (clk_en |=> card_irq == $past(pend))
      else $error("interrupt request does not follow enabled flags");

   enable_gates_a: // [R9]
      assert property (clk_en && (flag_q & en_q) == 8'h00 |=> !card_irq)
      else $error("interrupt raised with all flags disabled");

   enable_write_a: // [R10]
      assert property (clk_en && en_wr
                       |=> en_q == ($past(sfr_wdata) & scic_pkg::IRQ_MASK))
      else $error("enable register write lost");

   bank_protect_a: // [R17]
      assert property (clk_en && sfr_rd && hit_irq && bank && evt == 8'h00
                       |=> flag_q == $past(flag_q))
      else $error("flags cleared by read in wrong bank");

   retry_count_a: // [R11]
      assert property (clk_en |=> retry_limit ==
                       ($past(sel_q[scic_pkg::RETRY_BIT]) ? 3'h4 : 3'h5))
      else $error("retry count does not match select bit");

   port_pass_a: // [R13]
      assert property (clk_en && !route |=> alt_clk_pin_out == $past(port_func_out))
      else $error("pin not in port function while unrouted");

   prescale_wrap_a: // [R12]
      assert property (clk_en && route && div_wrap |=> alt_tgl_q != $past(alt_tgl_q))
      else $error("prescaler did not toggle at wrap");

   reset_values_a: // [R16]
      assert property ($rose(rst_n_q) |-> flag_q == 8'h00 && en_q == 8'h00
                       && sel_q[3:2] == 2'h2)
      else $error("reset values wrong");

   set_beats_clear_a: // [R19]
      assert property (clk_en && id_rd && evt != 8'h00
                       |=> (flag_q & $past(evt)) == $past(evt))
      else $error("event lost during clearing read");

   bank_output_a: // [R14]
      assert property (clk_en |=> register_bank_select == $past(bank))
      else $error("bank select output wrong");

   // flags only drop on a clearing read, and never while frozen
   flags_sticky_a: // [R2]
      assert property (clk_en && !id_rd |=> (flag_q & $past(flag_q)) == $past(flag_q))
      else $error("flag dropped without a read");

   frozen_flags_a: // [R2]
      assert property (!clk_en |=> flag_q == $past(flag_q))
      else $error("flags changed while clock enable low");

   lone_parity_a: // [R8]
      assert property (clk_en && parity_error && !char_done && !flag_q[scic_pkg::PAR_BIT]
                       |=> !flag_q[scic_pkg::PAR_BIT])
      else $error("parity flag set without character event");

   current_once_a: // [R3]
      assert property (clk_en && card_current_over && curr_over_q && !id_rd
                       |=> flag_q[scic_pkg::CURR_BIT] == $past(flag_q[scic_pkg::CURR_BIT]))
      else $error("held current fault re-armed the flag");

   voltage_once_a: // [R4]
      assert property (clk_en && !card_voltage_ok && !volt_ok_q && !id_rd
                       |=> flag_q[scic_pkg::VOLT_BIT] == $past(flag_q[scic_pkg::VOLT_BIT]))
      else $error("held voltage fault re-armed the flag");

   reserved_clear_a: // [R15]
      assert property (!flag_q[scic_pkg::RSVD_BIT] && !en_q[scic_pkg::RSVD_BIT])
      else $error("reserved bit stored");

   irq_raise_a: // [R18]
      assert property (clk_en && (flag_q & en_q) != 8'h00 |=> card_irq)
      else $error("pending enabled flag raised no request");

   enable_hold_a: // [R10]
      assert property (clk_en && !en_wr |=> en_q == $past(en_q))
      else $error("enable register changed without a write");

   id_readonly_a: // [R17]
      assert property (clk_en && sfr_wr && !sfr_rd && hit_irq && !bank && evt == 8'h00
                       |=> flag_q == $past(flag_q))
      else $error("write reached the identification flags");

   // register bus answers one cycle after the strobe
   read_valid_a: // [R17]
      assert property (clk_en |=> sfr_rdata_valid == $past(any_rd))
      else $error("read valid pulse wrong");

   id_read_data_a: // [R17]
      assert property (clk_en && id_rd |=> sfr_rdata == $past(flag_q))
      else $error("identification read returned wrong data");

   // selection register and prescaled pin
   sel_write_a: // [R14]
      assert property (clk_en && sel_wr |=> sel_q == ($past(sfr_wdata) & scic_pkg::SEL_MASK))
      else $error("selection register write lost");

   prescale_hold_a: // [R12]
      assert property (clk_en && route && !div_wrap |=> alt_tgl_q == $past(alt_tgl_q))
      else $error("prescaler toggled before wrap");

   pin_follows_a: // [R13]
      assert property (clk_en && route |=> alt_clk_pin_out == alt_tgl_q)
      else $error("pin not driven by prescaled clock");

   route_output_a: // [R13]
      assert property (clk_en |=> alt_clock_route == $past(route))
      else $error("route output wrong");

endmodule

// [verif/smart_card_irq_and_select_tb_top.sv]
/*
 * Self-checking bench for the card interrupt identification, enable and
 * selection block. Assumes scic_pkg is compiled first; the bench drives
 * the register strobes and event inputs itself, 1 ns after each edge.
 */
`timescale 1ns/10ps
module smart_card_irq_and_select_tb_top;
   logic sys_clk, reset_n, clk_en, sfr_wr, sfr_rd, port_func_out;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, ev, m, x;
   logic sfr_rdata_valid, card_irq, register_bank_select, alt_clock_route, alt_clk_pin_out;
   logic [2:0] retry_limit;
   logic card_current_over, card_voltage_ok;
   logic [7:0] ev_tab [9] = '{8'h80, 8'h20, 8'h10, 8'h08, 8'h04, 8'h02, 8'h03, 8'h05, 8'h01};
   int err_count = 0, comparisons = 0, cycles = 0, i, n;
   // level events: current rises, voltage falls, for one cycle
   assign card_current_over = ev[5];
   assign card_voltage_ok = ~ev[4];
   scic_irq_select scic_irq_select_i (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata), .sfr_rdata_valid(sfr_rdata_valid), .tx_buf_load(ev[7]),
      .card_current_over(card_current_over), .card_voltage_ok(card_voltage_ok),
      .wait_timeout(ev[3]), .tx_char_done(ev[2]), .rx_char_done(ev[1]),
      .parity_error(ev[0]), .port_func_out(port_func_out), .card_irq(card_irq),
      .retry_limit(retry_limit), .register_bank_select(register_bank_select),
      .alt_clock_route(alt_clock_route), .alt_clk_pin_out(alt_clk_pin_out));
   // clock, 10 ns period
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // hang guard, well above the few hundred cycles the tests need
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_count++;
         tally_and_finish;
      end
   end
   task tally_and_finish;
      $display("comparisons=%0d err_count=%0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk_byte(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task chk_bit(input logic got, input logic exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task step;
      @(posedge sys_clk);
      #1;
   endtask
   // one bus cycle; strobes and events last exactly one edge
   task cyc(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d,
            input logic [7:0] mk);
      step;
      sfr_rd = r;
      sfr_wr = w;
      sfr_addr = a;
      sfr_wdata = d;
      ev = mk;
      step;
      sfr_rd = 1'b0;
      sfr_wr = 1'b0;
      ev = 8'h00;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      cyc(1'b0, 1'b1, a, d, 8'h00);
   endtask
   // reserved bit 6 of the interrupt registers is masked off, never trusted
   task rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] k;
      k = (a == scic_pkg::IRQ_ADDR) ? scic_pkg::IRQ_MASK : 8'hff;
      cyc(1'b1, 1'b0, a, 8'h00, 8'h00);
      chk_bit(sfr_rdata_valid, 1'b1);
      chk_byte(sfr_rdata & k, exp & k);
   endtask
   // cycles between two changes of the alternate clock pin
   task half_period(output int cnt);
      logic p;
      cnt = 0;
      step;
      p = alt_clk_pin_out;
      for (int k = 0; k < 40 && alt_clk_pin_out === p; k++) step;
      p = alt_clk_pin_out;
      for (int k = 0; k < 40 && alt_clk_pin_out === p; k++) begin
         step;
         cnt++;
      end
   endtask
   initial begin
      reset_n = 1'b0;
      clk_en = 1'b1;
      {sfr_wr, sfr_rd, port_func_out} = 3'h0;
      {sfr_addr, sfr_wdata, ev} = 24'h0;
      repeat (12) @(posedge sys_clk);
      #1;
      chk_byte({5'h00, retry_limit}, 8'h05);
      chk_bit(card_irq, 1'b0);
      reset_n = 1'b1;
      repeat (2) @(posedge sys_clk);
      rd_chk(scic_pkg::SEL_ADDR, 8'h08);
      rd_chk(scic_pkg::IRQ_ADDR, 8'h00);
      // bank 1 exposes the enable register
      wr(scic_pkg::SEL_ADDR, 8'h09);
      step;
      chk_bit(register_bank_select, 1'b1);
      rd_chk(scic_pkg::IRQ_ADDR, 8'h00);
      wr(scic_pkg::IRQ_ADDR, 8'hbf);
      rd_chk(scic_pkg::IRQ_ADDR, 8'hbf);
      wr(scic_pkg::SEL_ADDR, 8'h08);
      step;
      chk_bit(register_bank_select, 1'b0);
      wr(scic_pkg::IRQ_ADDR, 8'hff);
      rd_chk(scic_pkg::IRQ_ADDR, 8'h00);
      // each event alone, the parity pairs, and a lone parity qualifier
      for (i = 0; i < 9; i++) begin
         m = ev_tab[i];
         x = (m == 8'h01) ? 8'h00 : m;
         cyc(1'b0, 1'b0, 8'h00, 8'h00, m);
         step;
         chk_bit(card_irq, |x);
         rd_chk(scic_pkg::IRQ_ADDR, x);
         rd_chk(scic_pkg::IRQ_ADDR, 8'h00);
         chk_bit(card_irq, 1'b0);
      end
      // only the transmit interrupt enabled
      wr(scic_pkg::SEL_ADDR, 8'h09);
      wr(scic_pkg::IRQ_ADDR, 8'h04);
      wr(scic_pkg::SEL_ADDR, 8'h08);
      cyc(1'b0, 1'b0, 8'h00, 8'h00, 8'h02);
      step;
      chk_bit(card_irq, 1'b0);
      cyc(1'b0, 1'b0, 8'h00, 8'h00, 8'h04);
      step;
      chk_bit(card_irq, 1'b1);
      rd_chk(scic_pkg::IRQ_ADDR, 8'h06);
      // event in the very cycle of a clearing read is kept
      cyc(1'b1, 1'b0, scic_pkg::IRQ_ADDR, 8'h00, 8'h02);
      chk_byte(sfr_rdata, 8'h00);
      rd_chk(scic_pkg::IRQ_ADDR, 8'h02);
      cyc(1'b1, 1'b0, 8'h55, 8'h00, 8'h00);
      chk_bit(sfr_rdata_valid, 1'b0);
      // frozen clock enable drops the event
      clk_en = 1'b0;
      cyc(1'b0, 1'b0, 8'h00, 8'h00, 8'h04);
      clk_en = 1'b1;
      rd_chk(scic_pkg::IRQ_ADDR, 8'h00);
      wr(scic_pkg::SEL_ADDR, 8'hff);
      rd_chk(scic_pkg::SEL_ADDR, 8'h1f);
      chk_byte({5'h00, retry_limit}, 8'h04);
      // divide by 1, 2, 4, 8; second interval avoids the switch-over one
      for (i = 0; i < 4; i++) begin
         wr(scic_pkg::SEL_ADDR, 8'h02 | (i[7:0] << 2));
         chk_bit(alt_clock_route, 1'b1);
         half_period(n);
         half_period(n);
         chk_byte(n[7:0], 8'h01 << i);
      end
      wr(scic_pkg::SEL_ADDR, 8'h08);
      port_func_out = 1'b1;
      repeat (2) step;
      chk_bit(alt_clk_pin_out, 1'b1);
      chk_bit(alt_clock_route, 1'b0);
      chk_byte({5'h00, retry_limit}, 8'h05);
      port_func_out = 1'b0;
      repeat (2) step;
      chk_bit(alt_clk_pin_out, 1'b0);
      tally_and_finish;
   end
endmodule
